// file: design/rxcfg_pkg.sv
/*
 * Shared constants for the receiver control block: register offsets,
 * field positions, reset values, serial-port and divider encodings.
 * Assumes a 7-bit register space reached over the three-wire port.
 */
package rxcfg_pkg;
    // ****************************************************************
    // Register offsets.
    // ****************************************************************
    localparam logic [6:0] FILT_CFG_ADDR = 7'h03;
    localparam logic [6:0] LO_HIGH_ADDR  = 7'h09;
    localparam logic [6:0] LO_MID_ADDR   = 7'h0a;
    localparam logic [6:0] LO_LOW_ADDR   = 7'h0b;
    localparam logic [6:0] AFE_CTL_ADDR  = 7'h19;
    localparam logic [6:0] CREC_CFG_ADDR = 7'h35;
    // ****************************************************************
    // Reset values.
    // ****************************************************************
    localparam logic [7:0] FILT_CFG_RST  = 8'h10;
    localparam logic [7:0] LO_HIGH_RST   = 8'h00;
    localparam logic [7:0] LO_MID_RST    = 8'h00;
    localparam logic [7:0] LO_LOW_RST    = 8'h00;
    localparam logic [7:0] AFE_CTL_RST   = 8'h10;
    localparam logic [7:0] CREC_CFG_RST  = 8'h00;
    // ****************************************************************
    // Field positions.
    // ****************************************************************
    localparam int LOW_DELAY_BIT  = 7;
    localparam int WIDE_BW_BIT    = 6;
    localparam int COARSE_LSB     = 3;
    localparam int FINE_LSB       = 0;
    localparam int XODIV_LSB      = 4;
    localparam int HIGH_SIDE_BIT  = 3;
    localparam int BAND_LSB       = 1;
    localparam int FRAC_BIT       = 0;
    localparam int CR_MODE_LSB    = 0;
    // ****************************************************************
    // Encodings and counts.
    // ****************************************************************
    localparam logic [2:0] DIV_RATIO_0   = 3'h4;
    localparam logic [2:0] DIV_RATIO_1   = 3'h5;
    localparam logic [2:0] DIV_RATIO_2   = 3'h6;
    localparam logic [1:0] CR_CLK_ONLY   = 2'h1;
    localparam logic [1:0] CR_RETIME     = 2'h2;
    localparam logic [1:0] CR_BOTH       = 2'h3;
    localparam logic [1:0] LAT_DEFAULT   = 2'h0;
    localparam logic [1:0] LAT_LOWER     = 2'h1;
    localparam logic [1:0] LAT_LOWEST    = 2'h2;
    localparam logic [1:0] LAT_RESERVED  = 2'h3;
    localparam int         BYTE_BITS     = 8;
    localparam int         SYNC_STAGES   = 3;
    localparam logic [15:0] CR_HALF_RST  = 16'h0040;
    typedef enum logic [1:0] {SP_ADDR, SP_DUMMY, SP_DATA, SP_IDLE}
        rxcfg_phase_t;
endpackage : rxcfg_pkg

// file: design/rxcfg_sync.sv
/*
 * Three-stage synchroniser for one pin input with agreement filter.
 * Assumes the caller's clock; output changes once stages two and three
 * agree.
 */
`timescale 1ns/1ps
module rxcfg_sync
    import rxcfg_pkg::*;
(
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic enable,
    input  wire logic pinIn,
    input  wire logic resetLevel,
    output logic      level
);
    logic [SYNC_STAGES-1:0] stage_reg;
    logic                   level_reg;
    wire                    agree = stage_reg[1] == stage_reg[2];

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            stage_reg <= '0;
            level_reg <= 1'b0;
        end else if (enable) begin
            stage_reg <= {stage_reg[SYNC_STAGES-2:0], pinIn};
            if (agree) begin
                level_reg <= stage_reg[2];
            end
        end
    end

    // Chip select must read high out of reset, so the level is inverted.
    assign level = level_reg ^ resetLevel;
endmodule : rxcfg_sync

// file: design/rxcfg_top.sv
/*
 * Control side of the receiver: three-wire serial register port, crystal
 * divider time base, synthesizer words, latency select and bit-clock
 * recovery with optional data re-timing.
 * Assumes one system clock far faster than the serial clock and the
 * demodulated data; serial pins and data are asynchronous inputs.
 */
`timescale 1ns/1ps
// How it works
// - Registers reached over clock, data, select.
// - Read drives data after one dummy byte.
// - Burst bytes step to next address.
// - Divide crystal clock to internal time base.
// - Divider codes 0,1,2 give 4,5,6.
// - Oscillator word held across three bytes.
// - Band code 0 disables synthesizer, 3/2/1 bands.
// - Recovery needs rate fields not both zero.
// - Mode selects clock output and re-timing.
// - Recovered clock twice rate, rising centred.
// - High-side bit places oscillator above carrier.
// - Wide bandwidth, plus buffer, lowest delay.
module rxcfg_top
    import rxcfg_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        clockEnable,
    input  wire logic        serialClock,
    input  wire logic        chip_select_n,
    input  wire logic        serialDataIn,
    output logic             serialDataOut,
    output logic             serialDataOe_n,
    input  wire logic        demodData,
    output logic             dataOut,
    output logic             recoveredClock,
    output logic             timeBaseTick,
    output logic [23:0]      lo_frequency_word,
    output logic [1:0]       band_divider_code,
    output logic             fractional_synth_enable,
    output logic             mixer_high_side_select,
    output logic [1:0]       latencyPath,
    output logic             synthEnable
);
    // ****************************************************************
    // Pin synchronisers.
    // ****************************************************************
    logic sclkLevel;
    logic csLevel;
    logic sdiLevel;
    logic rxLevel;

    rxcfg_sync uSyncClk (.clock(clock), .rst_n(rst_n),
        .enable(clockEnable), .pinIn(serialClock), .resetLevel(1'b0),
        .level(sclkLevel));
    rxcfg_sync uSyncCs (.clock(clock), .rst_n(rst_n),
        .enable(clockEnable), .pinIn(~chip_select_n),
        .resetLevel(1'b1), .level(csLevel));
    rxcfg_sync uSyncDi (.clock(clock), .rst_n(rst_n),
        .enable(clockEnable), .pinIn(serialDataIn), .resetLevel(1'b0),
        .level(sdiLevel));
    rxcfg_sync uSyncRx (.clock(clock), .rst_n(rst_n),
        .enable(clockEnable), .pinIn(demodData), .resetLevel(1'b0),
        .level(rxLevel));

    // ****************************************************************
    // Serial port.
    // ****************************************************************
    logic         sclkPrev_reg;
    logic         csPrev_reg;
    rxcfg_phase_t phase_reg;
    logic [2:0]   bitCnt_reg;
    logic [7:0]   shiftIn_reg;
    logic [7:0]   shiftOut_reg;
    logic [6:0]   addr_reg;
    logic         isRead_reg;
    logic         drive_reg;
    logic [7:0]   filtCfg_reg;
    logic [7:0]   loHigh_reg;
    logic [7:0]   loMid_reg;
    logic [7:0]   loLow_reg;
    logic [7:0]   afeCtl_reg;
    logic [7:0]   crecCfg_reg;

    // Chip select high holds the port idle and masks clock edges.
    wire csActive  = ~csLevel;
    wire riseEdge  = csActive & sclkLevel & ~sclkPrev_reg;
    wire fallEdge  = csActive & ~sclkLevel & sclkPrev_reg;
    wire csStart   = csActive & csPrev_reg;
    wire byteDone  = riseEdge && bitCnt_reg == 3'h7;
    wire [7:0] byteIn = {shiftIn_reg[6:0], sdiLevel};
    wire writeByte = byteDone && phase_reg == SP_DATA && !isRead_reg;

    function automatic logic [7:0] readMux(input logic [6:0] a,
        input logic [7:0] p, input logic [7:0] h, input logic [7:0] m,
        input logic [7:0] l, input logic [7:0] f, input logic [7:0] c);
        logic [7:0] v;
        v = 8'h00;
        case (a)
            FILT_CFG_ADDR: v = p;
            LO_HIGH_ADDR: v = h;
            LO_MID_ADDR:  v = m;
            LO_LOW_ADDR:  v = l;
            AFE_CTL_ADDR: v = f;
            CREC_CFG_ADDR: v = {6'h00, c[1:0]};
            default:      v = 8'h00;
        endcase
        return v;
    endfunction : readMux

    wire [7:0] readData = readMux(addr_reg, filtCfg_reg, loHigh_reg,
        loMid_reg, loLow_reg, afeCtl_reg, crecCfg_reg);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sclkPrev_reg <= 1'b0;
            csPrev_reg   <= 1'b1;
            phase_reg    <= SP_IDLE;
            bitCnt_reg   <= 3'h0;
            shiftIn_reg  <= 8'h00;
            shiftOut_reg <= 8'h00;
            addr_reg     <= 7'h00;
            isRead_reg   <= 1'b0;
            drive_reg    <= 1'b0;
        end else if (clockEnable) begin
            sclkPrev_reg <= sclkLevel;
            csPrev_reg   <= csLevel;
            if (!csActive) begin
                phase_reg <= SP_IDLE;
                bitCnt_reg <= 3'h0;
                drive_reg <= 1'b0;
            end else if (csStart) begin
                phase_reg <= SP_ADDR;
                bitCnt_reg <= 3'h0;
            end else begin
                if (riseEdge) begin
                    shiftIn_reg <= byteIn;
                    bitCnt_reg <= bitCnt_reg + 3'h1;
                end
                if (byteDone) begin
                    case (phase_reg)
                        SP_ADDR: begin
                            isRead_reg <= byteIn[7];
                            addr_reg <= byteIn[6:0];
                            phase_reg <= byteIn[7] ? SP_DUMMY : SP_DATA;
                        end
                        SP_DUMMY: begin
                            phase_reg <= SP_DATA;
                            drive_reg <= 1'b1;
                            shiftOut_reg <= readData;
                        end
                        SP_DATA: begin
                            addr_reg <= addr_reg + 7'h01;
                        end
                        default: phase_reg <= SP_IDLE;
                    endcase
                end
                // Next read byte is loaded after the address step.
                if (fallEdge && phase_reg == SP_DATA && isRead_reg) begin
                    if (bitCnt_reg == 3'h0) begin
                        shiftOut_reg <= readData;
                    end else begin
                        shiftOut_reg <= {shiftOut_reg[6:0], 1'b0};
                    end
                end
            end
        end
    end

    // Data leaves MSB first, changed on falling edges for the host.
    assign serialDataOut  = shiftOut_reg[7];
    assign serialDataOe_n = ~drive_reg;

    // ****************************************************************
    // Register file.
    // ****************************************************************
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            filtCfg_reg <= FILT_CFG_RST;
            loHigh_reg  <= LO_HIGH_RST;
            loMid_reg   <= LO_MID_RST;
            loLow_reg   <= LO_LOW_RST;
            afeCtl_reg  <= AFE_CTL_RST;
            crecCfg_reg <= CREC_CFG_RST;
        end else if (clockEnable && writeByte) begin
            case (addr_reg)
                FILT_CFG_ADDR: filtCfg_reg <= byteIn;
                LO_HIGH_ADDR:  loHigh_reg  <= byteIn;
                LO_MID_ADDR:   loMid_reg   <= byteIn;
                LO_LOW_ADDR:   loLow_reg   <= byteIn;
                AFE_CTL_ADDR:  afeCtl_reg  <= byteIn;
                CREC_CFG_ADDR: crecCfg_reg <= byteIn;
                default: ;
            endcase
        end
    end

    wire [1:0] xoCode   = afeCtl_reg[XODIV_LSB +: 2];
    wire [2:0] coarse   = filtCfg_reg[COARSE_LSB +: 3];
    wire [2:0] fine     = filtCfg_reg[FINE_LSB +: 3];
    wire       wideBw   = filtCfg_reg[WIDE_BW_BIT];
    wire       lowDelay = filtCfg_reg[LOW_DELAY_BIT];
    wire [1:0] crMode   = crecCfg_reg[CR_MODE_LSB +: 2];

    assign lo_frequency_word = {loHigh_reg, loMid_reg, loLow_reg};
    assign band_divider_code = afeCtl_reg[BAND_LSB +: 2];
    assign synthEnable = band_divider_code != 2'h0;
    assign fractional_synth_enable = afeCtl_reg[FRAC_BIT];
    assign mixer_high_side_select  = afeCtl_reg[HIGH_SIDE_BIT];
    // Reserved pairing is reported rather than silently remapped.
    assign latencyPath = !wideBw ? (lowDelay ? LAT_RESERVED
                                             : LAT_DEFAULT)
                                 : (lowDelay ? LAT_LOWEST
                                             : LAT_LOWER);

    // ****************************************************************
    // Crystal divider time base.
    // ****************************************************************
    logic [2:0] divCnt_reg;
    wire  [2:0] divRatio = (xoCode == 2'h0) ? DIV_RATIO_0
                         : (xoCode == 2'h2) ? DIV_RATIO_2 : DIV_RATIO_1;
    wire        divWrap  = divCnt_reg >= divRatio - 3'h1;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            divCnt_reg <= 3'h0;
        end else if (clockEnable) begin
            divCnt_reg <= divWrap ? 3'h0 : divCnt_reg + 3'h1;
        end
    end

    assign timeBaseTick = clockEnable & divWrap;

    // ****************************************************************
    // Bit-clock recovery.
    // ****************************************************************
    // The bit period is learned from edge spacing on the time base; a
    // free-running phase counter is pulled to each data edge.
    logic        rxPrev_reg;
    logic [15:0] edgeGap_reg;
    logic [15:0] half_reg;
    logic [15:0] phase16_reg;
    logic        crClk_reg;
    logic        retimed_reg;
    logic        dataOut_reg;
    logic        quarter_reg;

    wire crAvail  = (coarse != 3'h0) || (fine != 3'h0);
    wire rxEdge   = rxLevel ^ rxPrev_reg;
    wire halfDone = phase16_reg >= half_reg;
    wire useClock = crAvail && (crMode == CR_CLK_ONLY || crMode == CR_BOTH);
    wire useRetim = crAvail && (crMode == CR_RETIME || crMode == CR_BOTH);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rxPrev_reg  <= 1'b0;
            edgeGap_reg <= 16'h0000;
            half_reg    <= CR_HALF_RST;
            phase16_reg <= 16'h0000;
            crClk_reg   <= 1'b0;
            quarter_reg <= 1'b0;
            retimed_reg <= 1'b0;
        end else if (clockEnable && timeBaseTick) begin
            rxPrev_reg <= rxLevel;
            if (rxEdge) begin
                // Latest gap over three ticks is one bit; a quarter bit per clock
                // phase gives a clock at twice the data rate.
                if (edgeGap_reg > 16'h0003) begin
                    half_reg <= {2'b00, edgeGap_reg[15:2]};
                end
                edgeGap_reg <= 16'h0000;
                phase16_reg <= 16'h0000;
                crClk_reg   <= 1'b0;
                quarter_reg <= 1'b0;
            end else begin
                if (edgeGap_reg != 16'hffff) begin
                    edgeGap_reg <= edgeGap_reg + 16'h0001;
                end
                if (halfDone) begin
                    phase16_reg <= 16'h0000;
                    crClk_reg   <= ~crClk_reg;
                    quarter_reg <= ~quarter_reg;
                    if (!quarter_reg) begin
                        retimed_reg <= rxLevel;
                    end
                end else begin
                    phase16_reg <= phase16_reg + 16'h0001;
                end
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            dataOut_reg <= 1'b0;
        end else if (clockEnable) begin
            dataOut_reg <= useRetim ? retimed_reg : rxLevel;
        end
    end

    assign dataOut        = dataOut_reg;
    assign recoveredClock = useClock & crClk_reg;
endmodule : rxcfg_top

// file: test/rxcfg_monitor.sv
/*
 * Port checker for the receiver control block.
 * Assumes it is bound to every rxcfg_top instance.
 */
`timescale 1ns/1ps
module rxcfg_monitor (
    input wire logic        clock,
    input wire logic        rst_n,
    input wire logic        serialClock,
    input wire logic        chip_select_n,
    input wire logic        serialDataOut,
    input wire logic        serialDataOe_n,
    input wire logic        recoveredClock,
    input wire logic        timeBaseTick,
    input wire logic [23:0] lo_frequency_word,
    input wire logic [1:0]  band_divider_code,
    input wire logic        fractional_synth_enable,
    input wire logic        mixer_high_side_select,
    input wire logic [1:0]  latencyPath,
    input wire logic        synthEnable
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    // ********
    // Assertions.
    // ********
    oe_idle_a: assert property (
        chip_select_n [*8] |-> serialDataOe_n)
        else $error("data line driven while deselected");
    oe_release_a: assert property (
        $rose(chip_select_n) |-> ##[1:8] serialDataOe_n)
        else $error("data line not released");
    oe_fall_a: assert property (
        $fell(serialDataOe_n) |-> !chip_select_n && serialClock)
        else $error("turnaround outside dummy byte end");
    sdo_edge_a: assert property (
        $changed(serialDataOut) && !serialDataOe_n
        && $past(!serialDataOe_n) |-> !serialClock)
        else $error("read bit changed with serial clock high");
    synth_on_a: assert property (
        (band_divider_code != 2'h0) [*3] |-> synthEnable)
        else $error("synthesizer off with band set");
    synth_off_a: assert property (
        (band_divider_code == 2'h0) [*3] |-> !synthEnable)
        else $error("synthesizer on with band zero");
    tick_gap_a: assert property (
        timeBaseTick |=> (!timeBaseTick) [*3])
        else $error("time base ticks too close");
    config_quiet_a: assert property (
        !$stable({lo_frequency_word, band_divider_code,
        fractional_synth_enable, mixer_high_side_select,
        latencyPath}) |-> !chip_select_n)
        else $error("configuration changed while deselected");
    cover property ($fell(serialDataOe_n));
    cover property ($rose(recoveredClock));
    cover property ($rose(synthEnable));
endmodule : rxcfg_monitor
bind rxcfg_top rxcfg_monitor u_mon (.*);

// file: test/rxcfg_host.sv
/*
 * Host model driving the three-wire register port.
 * Assumes a system clock far faster than its serial clock.
 */
`timescale 1ns/1ps
module rxcfg_host (
    input  wire logic clock,
    input  wire logic devData,
    input  wire logic devOe_n,
    output logic      sclk,
    output logic      csN,
    output wire logic line
);
    logic       drvEn  = 1'b0;
    logic       drvBit = 1'b0;
    logic       junk   = 1'b0;
    logic [7:0] xbuf [0:7];
    // A released line toggles each clock but is sampled every 12 clocks, so it reads as one constant level.
    assign line = !devOe_n ? devData : (drvEn ? drvBit : junk);
    initial begin
        sclk = 1'b0;
        csN  = 1'b1;
    end
    always @(posedge clock) junk <= ~junk;
    task automatic bit_io(input logic drv, input logic b, output logic r);
        @(posedge clock);
        sclk   <= 1'b0;
        drvEn  <= drv;
        drvBit <= b;
        repeat (5) @(posedge clock);
        @(negedge clock);
        r = line;
        @(posedge clock);
        sclk <= 1'b1;
        repeat (5) @(posedge clock);
    endtask : bit_io
    task automatic byte_io(input logic drv, input logic [7:0] w,
                           output logic [7:0] r);
        for (int i = 7; i >= 0; i--) bit_io(drv, w[i], r[i]);
    endtask : byte_io
    // Burst access; xbuf holds the bytes of consecutive addresses.
    task automatic access(input logic rd, input logic [6:0] a, input int n);
        logic [7:0] r;
        @(posedge clock);
        csN <= 1'b0;
        repeat (6) @(posedge clock);
        byte_io(1'b1, {rd, a}, r);
        if (rd) byte_io(1'b0, 8'h00, r);
        for (int i = 0; i < n; i++) byte_io(!rd, xbuf[i], xbuf[i]);
        repeat (10) @(posedge clock);
        csN   <= 1'b1;
        drvEn <= 1'b0;
        repeat (10) @(posedge clock);
    endtask : access
    task automatic noise(input int n);
        logic r;
        for (int i = 0; i < n; i++) bit_io(1'b1, i[0], r);
    endtask : noise
endmodule : rxcfg_host

// file: test/rxcfg_top_tb.sv
/*
 * Self-checking bench for rxcfg_top through the host model.
 * Assumes a 25 MHz clock and an alternating demodulated stream.
 */
`timescale 1ns/1ps
module rxcfg_top_tb
    import rxcfg_pkg::*;
;
    localparam int BIT = 200;
    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    logic        clockEnable = 1'b1;
    logic        demodData = 1'b0;
    logic        demodRun = 1'b0;
    wire logic   sclk, csN, line;
    logic        sdo, oeN, dataOut, recClk, tick, synthEn, frac, hiSide;
    logic [23:0] loWord;
    logic [1:0]  band, latPath;
    logic        rcPrev = 1'b0, doPrev = 1'b0;
    int          errTotal = 0, numChecks = 0, cycles = 0, demodCnt = 0;
    int          rcRise = 0, doTog = 0;
    always #20 clock = ~clock;
    rxcfg_top u_dut (.clock(clock), .rst_n(rst_n),
        .clockEnable(clockEnable), .serialClock(sclk),
        .chip_select_n(csN), .serialDataIn(line), .serialDataOut(sdo),
        .serialDataOe_n(oeN), .demodData(demodData), .dataOut(dataOut),
        .recoveredClock(recClk), .timeBaseTick(tick),
        .lo_frequency_word(loWord), .band_divider_code(band),
        .fractional_synth_enable(frac), .mixer_high_side_select(hiSide),
        .latencyPath(latPath), .synthEnable(synthEn));
    rxcfg_host u_host (.clock(clock), .devData(sdo), .devOe_n(oeN),
        .sclk(sclk), .csN(csN), .line(line));
    // ********
    // Stream source, edge counters and watchdog.
    // ********
    always @(posedge clock) begin
        cycles <= cycles + 1;
        rcPrev <= recClk;
        doPrev <= dataOut;
        if (recClk === 1'b1 && rcPrev === 1'b0) rcRise <= rcRise + 1;
        if (dataOut !== doPrev) doTog <= doTog + 1;
        if (demodRun) begin
            demodCnt <= (demodCnt == BIT - 1) ? 0 : demodCnt + 1;
            if (demodCnt == BIT - 1) demodData <= ~demodData;
        end
    end
    always @(posedge clock) if (cycles == 90000) begin
        errTotal++;
        stopTest();
    end
    // ********
    // Tasks.
    // ********
    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        numChecks++;
        if (got !== exp) begin
            errTotal++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic check_rng(input int got, input int lo, input int hi);
        numChecks++;
        if (got < lo || got > hi) begin
            errTotal++;
            $display("[ERR] %0t count %0d not in %0d..%0d", $time, got, lo,
                     hi);
        end
    endtask : check_rng
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        u_host.xbuf[0] = d;
        u_host.access(1'b0, a, 1);
    endtask : wr
    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        u_host.access(1'b1, a, 1);
        check(u_host.xbuf[0], e);
    endtask : rd
    task automatic tick_gap(input int e);
        int n;
        n = 0;
        @(posedge clock iff tick === 1'b1);
        do begin
            @(posedge clock);
            n++;
        end while (tick !== 1'b1 && n < 20);
        check_rng(n, e, e);
    endtask : tick_gap
    task automatic stopTest();
        $display("checks %0d errors %0d", numChecks, errTotal);
        if (errTotal == 0 && numChecks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : stopTest
    // ********
    // Main sequence.
    // ********
    initial begin
        logic [6:0] ra [6];
        logic [7:0] rv [6];
        logic [1:0] latExp [4];
        logic [7:0] pv [4];
        logic [1:0] dv;
        ra = '{FILT_CFG_ADDR, LO_HIGH_ADDR, LO_MID_ADDR, LO_LOW_ADDR,
               AFE_CTL_ADDR, CREC_CFG_ADDR};
        rv = '{FILT_CFG_RST, LO_HIGH_RST, LO_MID_RST, LO_LOW_RST,
               AFE_CTL_RST, CREC_CFG_RST};
        latExp = '{2'h0, 2'h1, 2'h2, 2'h2};
        pv = '{8'h10, 8'h50, 8'hd9, 8'hd0};
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        repeat (10) @(posedge clock);
        for (int i = 0; i < 6; i++) rd(ra[i], rv[i]);
        rd(7'h7f, 8'h00);
        tick_gap(5);
        clockEnable <= 1'b0;
        repeat (8) @(posedge clock);
        check(tick, 1'b0);
        clockEnable <= 1'b1;
        // Word for a 434 MHz carrier, 400 kHz IF and a 16 MHz crystal.
        u_host.xbuf[0] = 8'h1b;
        u_host.xbuf[1] = 8'h19;
        u_host.xbuf[2] = 8'h9a;
        u_host.access(1'b0, LO_HIGH_ADDR, 3);
        check(loWord, 24'h1b199a);
        for (int i = 0; i < 3; i++) u_host.xbuf[i] = 8'h00;
        u_host.access(1'b1, LO_HIGH_ADDR, 3);
        check(u_host.xbuf[2], 8'h9a);
        check(u_host.xbuf[1], 8'h19);
        u_host.noise(16);
        check(loWord, 24'h1b199a);
        wr(7'h20, 8'h5a);
        rd(7'h20, 8'h00);
        // Fractional mode always set, as software must.
        for (int k = 0; k < 4; k++) begin
            dv = 2'(k % 3);
            wr(AFE_CTL_ADDR, {2'b00, dv, k[0], k[1:0], 1'b1});
            check(band, k[1:0]);
            check(synthEn, k != 0);
            check({hiSide, frac}, {k[0], 1'b1});
            rd(AFE_CTL_ADDR, {2'b00, dv, k[0], k[1:0], 1'b1});
            tick_gap(4 + k % 3);
        end
        for (int k = 0; k < 4; k++) begin
            wr(FILT_CFG_ADDR, pv[k]);
            check(latPath, latExp[k]);
        end
        demodRun <= 1'b1;
        for (int k = 0; k < 5; k++) begin
            wr(FILT_CFG_ADDR, (k == 4) ? 8'h00 : 8'h10);
            wr(CREC_CFG_ADDR, (k == 4) ? 8'h03 : 8'(k));
            repeat (2000) @(posedge clock);
            rcRise <= 0;
            doTog <= 0;
            repeat (2000) @(posedge clock);
            if (k[0] && k < 4) check_rng(rcRise, 18, 22);
            else check_rng(rcRise, 0, 0);
            check_rng(doTog, 9, 11);
        end
        rst_n <= 1'b0;
        repeat (10) @(posedge clock);
        check(loWord, 24'h000000);
        check(oeN, 1'b1);
        rst_n <= 1'b1;
        repeat (10) @(posedge clock);
        rd(CREC_CFG_ADDR, CREC_CFG_RST);
        stopTest();
    end
endmodule : rxcfg_top_tb
